// *** design/mapped_ctrl_reg.sv ***
// mapped control register bank reached through the core's external data space
`timescale 1ns/1ns
`include "mapped_ctrl_reg_defines.svh"

// Notes on behaviour
// R1: every register in this bank is reachable by the embedded core through its external data space.
// R2: moves through the 16-bit data pointer reach the bank when the high address byte is 7Fh.
// R3: moves through index registers zero or one reach the bank with the high byte taken from the page register.
// R4: part of the bank also answers the host port, mailbox window, embedded controller interface and power block.
// R5: host writes to port 60h or 64h fill the data the core reads at F1h, and core writes to F1h fill what the host reads at 60h.
// R6: the status register resets to 00h, is read-only to the host at 64h and read-write to the core at F2h.
// R7: interrupt source group 0 at 00h resets to 00h and a core write clears the written one bits.
// R8: during an index move the page register drives the high address byte, and the page register resets to 00h.
// R9: unused offsets of the page complete with no side effect and read as zero.
module mapped_ctrl_reg
    import mapped_ctrl_reg_pkg::*;
#(
    parameter int IRQ_WIDTH = 8
)
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // core external data access
    input  wire logic                 core_rd,
    input  wire logic                 core_wr,
    input  wire logic                 core_use_index,
    input  wire logic                 core_index_sel,
    input  wire logic [15:0]          core_data_ptr,
    input  wire logic [7:0]           core_r0,
    input  wire logic [7:0]           core_r1,
    input  wire logic [7:0]           core_wdata,
    output logic      [7:0]           core_rdata,
    output logic                      core_hit,
    // page register written by the core's special function path
    input  wire logic                 page_wr,
    input  wire logic [7:0]           page_wdata,
    output logic      [7:0]           ext_page_reg,
    // host port
    input  wire logic                 host_rd,
    input  wire logic                 host_wr,
    input  wire logic [7:0]           host_port,
    input  wire logic [7:0]           host_wdata,
    output logic      [7:0]           host_rdata,
    // other bank users: mailbox window, controller iface, power block
    input  wire logic                 side_wr,
    input  wire logic [7:0]           side_addr,
    input  wire logic [7:0]           side_wdata,
    output logic      [7:0]           side_rdata,
    // event inputs and control outputs
    input  wire logic [IRQ_WIDTH-1:0] irq0_events,
    output logic                      addr_line_gate,
    output logic      [7:0]           config_zero,
    output logic      [7:0]           boot_rom_config,
    output logic      [7:0]           clock_calendar_control
);

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    access_mode_t mode;
    logic [15:0]  core_addr;
    logic [7:0]   off;
    logic         rd_hit;
    logic         wr_hit;

    // R2 R3 R8: index moves take the high byte from the page register
    assign mode      = core_use_index ? ACC_INDEX : ACC_POINTER;
    assign core_addr = (mode == ACC_INDEX) ?
                       {ext_page_reg, core_index_sel ? core_r1 : core_r0} :
                       core_data_ptr;
    assign off       = core_addr[7:0];
    // R1 R2: bank decoded only on page 7Fh
    assign core_hit  = (core_addr[15:8] == `MCR_PAGE) && (core_rd || core_wr);
    assign rd_hit    = core_hit && core_rd;
    assign wr_hit    = core_hit && core_wr;

    // ---------------------------------------------------------------
    // page register
    // ---------------------------------------------------------------
    // R8: page register, resets to 00h
    always_ff @(posedge clk)
    begin
        if (srst)
            ext_page_reg <= `MCR_PAGE_RESET;
        else if (page_wr)
            ext_page_reg <= page_wdata;
    end

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [IRQ_WIDTH-1:0] irq0_src_q;
    logic [7:0]           irq0_mask_q;
    logic [7:0]           host_in_q;
    logic [7:0]           host_out_q;
    logic [7:0]           status_q;
    logic [7:0]           hib_timer_q;
    logic [7:0]           cfg0_q;
    logic [7:0]           clk_ctl_q;
    logic [7:0]           lo_idx_q;
    logic [7:0]           lo_data_q;
    logic [7:0]           hi_idx_q;
    logic [7:0]           hi_data_q;
    logic [7:0]           gate_q;
    logic [7:0]           rom_cfg_q;
    logic [7:0]           obf_ctl_q;
    logic                 host_data_wr;
    logic                 side_hit_mask;

    assign host_data_wr  = host_wr && (host_port == `HOST_PORT_DATA ||
                                       host_port == `HOST_PORT_CMD);
    // R4: the side path reaches only the mask register here
    assign side_hit_mask = side_wr && (side_addr == `OFF_IRQ0_MASK);

    // events may come from pins, so two flops sit before any logic;
    // this costs two cycles of latency on every source bit
    logic [IRQ_WIDTH-1:0] evt_meta_q;
    logic [IRQ_WIDTH-1:0] evt_sync_q;
    logic                 src_clr;

    // two-flop synchroniser, only the second flop is read
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            evt_meta_q <= '0;
            evt_sync_q <= '0;
        end
        else
        begin
            evt_meta_q <= irq0_events;
            evt_sync_q <= evt_meta_q;
        end
    end

    // core write to the source offset clears the ones it writes
    assign src_clr = wr_hit && (off == `OFF_IRQ0_SOURCE);

    // R7: per bit, set wins over the write-one clear so no event is lost
    for (genvar gi = 0; gi < IRQ_WIDTH; gi++)
    begin : g_src
        always_ff @(posedge clk)
        begin
            if (srst)
                irq0_src_q[gi] <= 1'b0;
            else if (evt_sync_q[gi])
                irq0_src_q[gi] <= 1'b1;
            else if (src_clr && core_wdata[gi])
                irq0_src_q[gi] <= 1'b0;
        end
    end

    // core writes win over side writes in the same cycle
    always_ff @(posedge clk)
    begin
        if (srst)
            irq0_mask_q <= `RST_ZERO;
        else if (wr_hit && off == `OFF_IRQ0_MASK)
            irq0_mask_q <= core_wdata;
        else if (side_hit_mask)
            irq0_mask_q <= side_wdata;
    end

    // R5: host to core data path, input-full flag set by the host
    always_ff @(posedge clk)
    begin
        if (srst)
            host_in_q <= `RST_ZERO;
        else if (host_data_wr)
            host_in_q <= host_wdata;
    end

    // R5: core to host data path; aux register shares the host view
    always_ff @(posedge clk)
    begin
        if (srst)
            host_out_q <= `RST_ZERO;
        else if (wr_hit && (off == `OFF_HOST_DATA ||
                            off == `OFF_AUX_HOST_DATA))
            host_out_q <= core_wdata;
    end

    // R6: status; flags track the data hand-off, hardware set wins
    always_ff @(posedge clk)
    begin
        if (srst)
            status_q <= `RST_ZERO;
        else
        begin
            if (wr_hit && off == `OFF_HOST_STATUS)
                status_q <= core_wdata;
            if (rd_hit && off == `OFF_HOST_DATA)
                status_q[`STS_IBF_BIT] <= 1'b0;
            if (host_rd && host_port == `HOST_PORT_DATA)
                status_q[`STS_OBF_BIT] <= 1'b0;
            if (host_data_wr)
            begin
                status_q[`STS_IBF_BIT] <= 1'b1;
                status_q[`STS_CMD_BIT] <= (host_port == `HOST_PORT_CMD);
            end
            if (wr_hit && (off == `OFF_HOST_DATA ||
                           off == `OFF_AUX_HOST_DATA))
                status_q[`STS_OBF_BIT] <= 1'b1;
        end
    end

    // plain read-write registers with their own reset values
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hib_timer_q <= `RST_ZERO;
            cfg0_q      <= `RST_ZERO;
            clk_ctl_q   <= `RST_CLK_CAL_CTL;
            lo_idx_q    <= `RST_ZERO;
            lo_data_q   <= `RST_ZERO;
            hi_idx_q    <= `RST_ZERO;
            hi_data_q   <= `RST_ZERO;
            rom_cfg_q   <= `RST_ZERO;
            obf_ctl_q   <= `RST_ZERO;
        end
        else if (wr_hit)
        begin
            case (off)
                `OFF_HIB_TIMER:     hib_timer_q <= core_wdata;
                `OFF_CONFIG_ZERO:   cfg0_q      <= core_wdata;
                `OFF_CLK_CAL_CTL:   clk_ctl_q   <= core_wdata;
                `OFF_CMOS_LO_INDEX: lo_idx_q    <= core_wdata;
                `OFF_CMOS_LO_DATA:  lo_data_q   <= core_wdata;
                `OFF_CMOS_HI_INDEX: hi_idx_q    <= core_wdata;
                `OFF_CMOS_HI_DATA:  hi_data_q   <= core_wdata;
                `OFF_BOOT_ROM_CFG:  rom_cfg_q   <= core_wdata;
                `OFF_OBF_CTL:       obf_ctl_q   <= core_wdata;
                // R9: other offsets, including F0h, store nothing
                default:            ;
            endcase
        end
    end

    // gate bit: direct write, or set/clear strobes whose data is ignored
    always_ff @(posedge clk)
    begin
        if (srst)
            gate_q <= `RST_GATE_CTL;
        else if (wr_hit && off == `OFF_GATE_CTL)
            gate_q <= core_wdata;
        else if (wr_hit && off == `OFF_GATE_SET)
            gate_q[0] <= 1'b1;
        else if (wr_hit && off == `OFF_GATE_CLR)
            gate_q[0] <= 1'b0;
    end

    // ---------------------------------------------------------------
    // read paths
    // ---------------------------------------------------------------
    // R1 R9: core read mux, unused and write-only offsets read zero
    always_comb
    begin
        core_rdata = `RST_ZERO;
        if (rd_hit)
        begin
            case (off)
                `OFF_IRQ0_SOURCE:   core_rdata = 8'(irq0_src_q);
                `OFF_IRQ0_MASK:     core_rdata = irq0_mask_q;
                `OFF_HOST_DATA:     core_rdata = host_in_q;
                `OFF_HOST_STATUS:   core_rdata = status_q;
                `OFF_HIB_TIMER:     core_rdata = hib_timer_q;
                `OFF_CONFIG_ZERO:   core_rdata = cfg0_q;
                `OFF_CLK_CAL_CTL:   core_rdata = clk_ctl_q;
                `OFF_CMOS_LO_INDEX: core_rdata = lo_idx_q;
                `OFF_CMOS_LO_DATA:  core_rdata = lo_data_q;
                `OFF_CMOS_HI_INDEX: core_rdata = hi_idx_q;
                `OFF_CMOS_HI_DATA:  core_rdata = hi_data_q;
                `OFF_GATE_CTL:      core_rdata = gate_q;
                `OFF_BOOT_ROM_CFG:  core_rdata = rom_cfg_q;
                `OFF_OBF_CTL:       core_rdata = obf_ctl_q;
                default:            core_rdata = `RST_ZERO;
            endcase
        end
    end

    // R4 R5 R6: host sees data at 60h and status read-only at 64h
    always_comb
    begin
        case (host_port)
            `HOST_PORT_DATA: host_rdata = host_out_q;
            `HOST_PORT_CMD:  host_rdata = status_q;
            default:         host_rdata = `RST_ZERO;
        endcase
    end

    // R4: side path reads the shared mask register
    assign side_rdata = (side_addr == `OFF_IRQ0_MASK) ? irq0_mask_q
                                                     : `RST_ZERO;

    // control outputs straight from registers
    assign addr_line_gate         = gate_q[0];
    assign config_zero            = cfg0_q;
    assign boot_rom_config        = rom_cfg_q;
    assign clock_calendar_control = clk_ctl_q;

endmodule

// *** design/mapped_ctrl_reg_defines.svh ***
// offsets, reset values and field positions of the mapped control bank
`ifndef MAPPED_CTRL_REG_DEFINES_SVH
`define MAPPED_CTRL_REG_DEFINES_SVH

// page selecting the bank in external data space
`define MCR_PAGE            8'h7F
`define MCR_PAGE_RESET      8'h00

// offsets within the page
`define OFF_IRQ0_SOURCE     8'h00
`define OFF_IRQ0_MASK       8'h01
`define OFF_RESERVED_F0     8'hF0
`define OFF_HOST_DATA       8'hF1
`define OFF_HOST_STATUS     8'hF2
`define OFF_HIB_TIMER       8'hF3
`define OFF_CONFIG_ZERO     8'hF4
`define OFF_CLK_CAL_CTL     8'hF5
`define OFF_CMOS_LO_INDEX   8'hF6
`define OFF_CMOS_LO_DATA    8'hF7
`define OFF_CMOS_HI_INDEX   8'hF8
`define OFF_CMOS_HI_DATA    8'hF9
`define OFF_AUX_HOST_DATA   8'hFA
`define OFF_GATE_CTL        8'hFB
`define OFF_BOOT_ROM_CFG    8'hFC
`define OFF_OBF_CTL         8'hFD
`define OFF_GATE_SET        8'hFE
`define OFF_GATE_CLR        8'hFF

// host port numbers
`define HOST_PORT_DATA      8'h60
`define HOST_PORT_CMD       8'h64

// reset values
`define RST_ZERO            8'h00
`define RST_CLK_CAL_CTL     8'h80
`define RST_GATE_CTL        8'h01

// status bit positions
`define STS_OBF_BIT         0
`define STS_IBF_BIT         1
`define STS_CMD_BIT         3

`endif

// *** design/mapped_ctrl_reg_pkg.sv ***
// types shared by the mapped control bank
package mapped_ctrl_reg_pkg;
    // which path of the core produced the high address byte
    typedef enum logic
    {
        ACC_POINTER,
        ACC_INDEX
    } access_mode_t;
endpackage

// *** verif/core_xdata_model.sv ***
// behavioural core issuing external data moves and page loads
`timescale 1ns/1ns
module core_xdata_model (
    // clock
    input  wire logic       clk,
    // external data move
    output logic            core_rd,
    output logic            core_wr,
    output logic            core_use_index,
    output logic            core_index_sel,
    output logic [15:0]     core_data_ptr,
    output logic [7:0]      core_r0,
    output logic [7:0]      core_r1,
    output logic [7:0]      core_wdata,
    input  wire logic [7:0] core_rdata,
    // page register load
    output logic            page_wr,
    output logic [7:0]      page_wdata
);
    // idle; address and data lines carry junk between moves
    initial
    begin
        {core_rd, core_wr, core_use_index, core_index_sel, page_wr} = '0;
        {core_data_ptr, core_r0, core_r1, core_wdata, page_wdata} = '1;
    end
    // pointer move, or index r0/r1 under the page
    task automatic xfer(input bit w, input bit idx, input bit sel,
                        input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk);
        core_rd <= !w;
        core_wr <= w;
        core_use_index <= idx;
        core_index_sel <= sel;
        core_data_ptr <= idx ? ~a : a;
        core_r0 <= sel ? ~a[7:0] : a[7:0];
        core_r1 <= sel ? a[7:0] : ~a[7:0];
        core_wdata <= w ? d : ~d;
        @(posedge clk);
        q = core_rdata;
        core_rd <= 1'b0;
        core_wr <= 1'b0;
        core_data_ptr <= ~core_data_ptr;
        core_wdata <= ~core_wdata;
    endtask
    // page load, strobe held one cycle
    task automatic set_page(input logic [7:0] p);
        @(posedge clk);
        page_wr <= 1'b1;
        page_wdata <= p;
        @(posedge clk);
        page_wr <= 1'b0;
        page_wdata <= ~p;
    endtask
endmodule

// *** verif/mapped_ctrl_reg_chk.sv ***
// assertion checker for the mapped control bank
`timescale 1ns/1ns
module mapped_ctrl_reg_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // core moves and page
    input wire logic        core_rd,
    input wire logic        core_wr,
    input wire logic        core_use_index,
    input wire logic [15:0] core_data_ptr,
    input wire logic [7:0]  core_wdata,
    input wire logic [7:0]  core_rdata,
    input wire logic        core_hit,
    input wire logic        page_wr,
    input wire logic [7:0]  page_wdata,
    input wire logic [7:0]  ext_page_reg,
    // host side and outputs
    input wire logic [7:0]  host_port,
    input wire logic [7:0]  host_rdata,
    input wire logic [7:0]  config_zero
);
    // pointer move hitting the page; index moves are left out here
    wire logic       dp = core_hit && !core_use_index;
    wire logic [7:0] lo = core_data_ptr[7:0];
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_PAGE_RST: assert property (
        $past(srst) |-> ext_page_reg == 8'h00)
        else $error("page register not cleared");
    AST_PAGE_LOAD: assert property (
        page_wr |=> ext_page_reg == $past(page_wdata))
        else $error("page register did not load");
    AST_POINTER_HIT: assert property (
        (core_rd || core_wr) && !core_use_index
        |-> core_hit == (core_data_ptr[15:8] == 8'h7F))
        else $error("pointer decode wrong");
    AST_INDEX_HIT: assert property (
        (core_rd || core_wr) && core_use_index
        |-> core_hit == (ext_page_reg == 8'h7F))
        else $error("index decode wrong");
    AST_WRITE_LANDS: assert property (
        core_wr && dp && lo == 8'hF4 |=> config_zero == $past(core_wdata))
        else $error("config write lost");
    AST_OFF_PAGE: assert property (
        core_wr && !core_hit |=> $stable(config_zero))
        else $error("off page write took effect");
    AST_RSVD_ZERO: assert property (
        core_rd && dp && lo == 8'hF0 |-> core_rdata == 8'h00)
        else $error("reserved offset read not zero");
    AST_CORE_TO_HOST: assert property (
        core_wr && dp && lo == 8'hF1 ##1 host_port == 8'h60
        |-> host_rdata == $past(core_wdata))
        else $error("host data port missed core write");
endmodule
bind mapped_ctrl_reg mapped_ctrl_reg_chk mapped_ctrl_reg_chk_inst (.*);

// *** verif/mapped_ctrl_reg_tb.sv ***
// self-checking bench for the mapped control bank
`timescale 1ns/1ns
module mapped_ctrl_reg_tb;
    logic        clk = 1'b0, srst = 1'b1;
    logic        host_rd = 1'b0, host_wr = 1'b0, side_wr = 1'b0;
    logic [7:0]  host_port = 8'h64, host_wdata = 8'h00, side_addr = 8'h01;
    logic [7:0]  side_wdata = 8'h00, irq0_events = 8'h00;
    logic        core_rd, core_wr, core_use_index, core_index_sel;
    logic        core_hit, page_wr, addr_line_gate;
    logic [15:0] core_data_ptr;
    logic [7:0]  core_r0, core_r1, core_wdata, core_rdata, page_wdata;
    logic [7:0]  ext_page_reg, host_rdata, side_rdata, config_zero;
    logic [7:0]  boot_rom_config, clock_calendar_control, q, hout;
    logic [7:0]  mdl [256];
    logic [7:0]  rw [12] = '{8'h01, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6,
                             8'hF7, 8'hF8, 8'hF9, 8'hFB, 8'hFC, 8'hFD};
    int          seed = 56, n_errors = 0, cmp_count = 0, cyc = 0;
    always #50 clk = ~clk;
    mapped_ctrl_reg mapped_ctrl_reg_inst (.*);
    core_xdata_model core_xdata_model_inst (.*);
    // hang guard, far above the several hundred cycles needed
    always @(posedge clk) if (++cyc == 8000) summarize(1);
    task automatic summarize(input int extra);
        n_errors += extra;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // core move, path and index register picked at random
    task automatic mv(input bit w, input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        r = 2'($random(seed));
        core_xdata_model_inst.xfer(w, r[0], r[1], {8'h7F, a}, d, q);
    endtask
    // reads clear input full after the data offset
    task automatic rd(input logic [7:0] a);
        mv(1'b0, a, 8'h00);
        chk(q, mdl[a]);
        if (a == 8'hF1) mdl[8'hF2][1] = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        mv(1'b1, a, d);
        if (a inside {rw}) mdl[a] = d;
        if (a == 8'h00) mdl[0] &= ~d;
        if (a >= 8'hFE) mdl[8'hFB][0] = !a[0];
        if (a inside {8'hF1, 8'hFA}) hout = d;
        mdl[8'hF2][0] |= a inside {8'hF1, 8'hFA};
    endtask
    // one host cycle, then the port under it is looked at
    task automatic hcyc(input bit w, input logic [7:0] p, input logic [7:0] d);
        @(posedge clk);
        host_wr <= w;
        host_rd <= !w;
        host_port <= p;
        host_wdata <= d;
        @(posedge clk);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        host_wdata <= ~d;
        if (w) mdl[8'hF1] = d;
        mdl[8'hF2][1] |= w;
        if (w) mdl[8'hF2][3] = (p == 8'h64);
        if (!w && p == 8'h60) mdl[8'hF2][0] = 1'b0;
        @(negedge clk);
        chk(host_rdata, p == 8'h64 ? mdl[8'hF2] : hout);
    endtask
    //------------------------------------------------------------------
    // stimulus
    //------------------------------------------------------------------
    initial
    begin
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[8'hF5] = 8'h80;
        mdl[8'hFB] = 8'h01;
        hout = 8'h00;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(ext_page_reg, 8'h00);
        chk(host_rdata, 8'h00);
        host_port <= 8'h60;
        core_xdata_model_inst.set_page(8'h7F);
        @(negedge clk);
        chk(ext_page_reg, 8'h7F);
        for (int a = 0; a < 256; a++) rd(8'(a));
        repeat (3) foreach (rw[i]) wr(rw[i], 8'($random(seed)));
        foreach (rw[i]) rd(rw[i]);
        chk(config_zero, mdl[8'hF4]);
        chk(clock_calendar_control, mdl[8'hF5]);
        chk(boot_rom_config, mdl[8'hFC]);
        core_xdata_model_inst.xfer(1'b1, 1'b0, 1'b0, 16'h7EF4, 8'hA5, q);
        core_xdata_model_inst.set_page(8'h7E);
        core_xdata_model_inst.xfer(1'b1, 1'b1, 1'b0, 16'h7FF4, 8'h5A, q);
        core_xdata_model_inst.set_page(8'h7F);
        rd(8'hF4);
        wr(8'hF0, 8'hFF);
        wr(8'hFF, 8'hFF);
        @(negedge clk);
        chk(8'(addr_line_gate), 8'h00);
        wr(8'hFE, 8'hFF);
        @(negedge clk);
        chk(8'(addr_line_gate), 8'h01);
        foreach (rw[i]) rd(rw[i] | 8'h0E);
        @(posedge clk) irq0_events <= 8'hA5;
        @(posedge clk) irq0_events <= 8'h00;
        // events pass two synchroniser flops before they set a bit
        repeat (2) @(posedge clk);
        mdl[0] = 8'hA5;
        rd(8'h00);
        wr(8'h00, 8'h05);
        rd(8'h00);
        hcyc(1'b1, 8'h64, 8'hC3);
        rd(8'hF1);
        hcyc(1'b1, 8'h60, 8'h3C);
        rd(8'hF1);
        wr(8'hF1, 8'h96);
        hcyc(1'b0, 8'h64, 8'h00);
        hcyc(1'b0, 8'h60, 8'h00);
        wr(8'hFA, 8'h69);
        hcyc(1'b0, 8'h60, 8'h00);
        hcyc(1'b0, 8'h64, 8'h00);
        @(posedge clk);
        side_wr <= 1'b1;
        side_wdata <= 8'h7E;
        @(posedge clk);
        side_wr <= 1'b0;
        side_wdata <= 8'h81;
        mdl[8'h01] = 8'h7E;
        rd(8'h01);
        chk(side_rdata, 8'h7E);
        summarize(0);
    end
endmodule
